//--- src/asp_pkg.sv
// Purpose: shared constants of the serial audio clocking and output port
// Assumes: 100 MHz system clock, 8-bit register port
// Notes: offsets are byte addresses of the register port
package asp_pkg;
  // register map
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int HOST_EN_BIT = 7;
  localparam int FMT_LSB = 0;
  localparam int SPD_LSB = 2;
  localparam int DIV_LSB = 4;
  localparam logic [7:0] GLOBAL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  // format codes
  localparam logic [1:0] FMT_LJ = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_TDM = 2'h2;
  localparam logic [1:0] FMT_RSV = 2'h3;
  // mode codes; the first three double as the speed in effect
  localparam logic [1:0] SPD_SINGLE = 2'h0;
  localparam logic [1:0] SPD_DOUBLE = 2'h1;
  localparam logic [1:0] SPD_QUAD = 2'h2;
  localparam logic [1:0] SPD_SLAVE = 2'h3;
  // pre-divider codes and their ratios in half master-clock periods
  localparam logic [2:0] DIV_1P5 = 3'h1;
  localparam logic [2:0] DIV_2 = 3'h2;
  localparam logic [2:0] DIV_3 = 3'h3;
  localparam logic [2:0] DIV_4 = 3'h4;
  localparam logic [3:0] RATIO_1 = 4'h2;
  localparam logic [3:0] RATIO_1P5 = 4'h3;
  localparam logic [3:0] RATIO_2 = 4'h4;
  localparam logic [3:0] RATIO_3 = 4'h6;
  localparam logic [3:0] RATIO_4 = 4'h8;
  // bit clock half period in divided master-clock half periods
  localparam logic [2:0] HALF_LR_SINGLE = 3'h4;
  localparam logic [2:0] HALF_LR_DOUBLE = 3'h2;
  localparam logic [2:0] HALF_ONE = 3'h1;
  // frame layout
  localparam logic [7:0] WORD_BITS = 8'h18;
  localparam logic [2:0] TDM_CHANNELS = 3'h6;
  localparam logic [4:0] WORD_MSB = 5'h17;
  localparam int SAMPLE_W = 24;
  localparam int CHANNELS = 6;
  // auto-detect thresholds, divided master-clock half periods per frame
  localparam logic [9:0] DET_SINGLE_MIN = 10'h180;
  localparam logic [9:0] DET_DOUBLE_MIN = 10'h0C0;
  localparam logic [9:0] DET_SAT = 10'h3FF;
  // synchroniser lanes
  localparam int SY_MCLK = 0;
  localparam int SY_XTAL = 1;
  localparam int SY_SCLK = 2;
  localparam int SY_FCLK = 3;
  localparam int SY_FMT = 4;
  localparam int SY_SPD = 6;
  localparam int SY_DIV = 8;
  localparam int SY_XSEL = 11;
  localparam int SYNC_W = 12;
endpackage

//--- src/asp_sync_if.sv
// Purpose: carries raw pin levels to the synchroniser and clean levels back
// Assumes: one clock domain on the clean side
// Notes: width set by the instantiating module
`timescale 1ns/1ps
interface asp_sync_if #(parameter int W = 12);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync_side(input raw, output clean);
  modport user_side(output raw, input clean);
endinterface

//--- src/asp_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter per pin
// Assumes: pins asynchronous to clk
// Notes: clean level moves only once stages two and three agree
`timescale 1ns/1ps
module asp_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  asp_sync_if.sync_side s
);
  localparam int W = $bits(s.raw);
  logic [W-1:0] ff1_q;
  logic [W-1:0] ff2_q;
  logic [W-1:0] ff3_q;
  logic [W-1:0] clean_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ff1_q[i] <= 1'b0;
        ff2_q[i] <= 1'b0;
        ff3_q[i] <= 1'b0;
        clean_q[i] <= 1'b0;
      end else begin
        ff1_q[i] <= s.raw[i];
        ff2_q[i] <= ff1_q[i];
        ff3_q[i] <= ff2_q[i];
        if (ff2_q[i] == ff3_q[i]) begin
          clean_q[i] <= ff3_q[i];
        end
      end
    end
  end

  assign s.clean = clean_q;
endmodule

//--- src/asp_port.sv
// Purpose: clock source, master/slave clocking and serial audio output framing
// Assumes: master clock below a quarter of clk, since pins are oversampled
// Notes: all pin timing runs on clk through one-cycle enables
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module asp_port
  import asp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic use_crystal,
  input wire logic crystal_input,
  output logic crystal_output,
  input wire logic mclk_i,
  output logic mclk_o,
  output logic mclk_oe,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic frame_clock_i,
  output logic frame_clock_o,
  output logic frame_clock_oe,
  output logic serial_data_out_a,
  output logic serial_data_out_b,
  output logic serial_data_out_c,
  output logic serial_data_out_d,
  input wire logic format_select_hi,
  input wire logic format_select_lo,
  input wire logic speed_select_hi,
  input wire logic speed_select_lo,
  input wire logic [2:0] clock_div_select,
  input wire logic [SAMPLE_W*CHANNELS-1:0] samples,
  output logic sample_take,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  //////////////////////////////////////////////////////////////////////////////
  // pins and configuration
  asp_sync_if #(.W(SYNC_W)) pin_if ();
  assign pin_if.raw = {use_crystal, clock_div_select, speed_select_hi, speed_select_lo,
                       format_select_hi, format_select_lo, frame_clock_i, sclk_i,
                       crystal_input, mclk_i};
  asp_pin_sync u_sync (.clk(clk), .rst_n(rst_n), .s(pin_if));
  wire [SYNC_W-1:0] cl = pin_if.clean;

  logic [7:0] global_q;
  logic [7:0] mode_q;
  wire host_en = global_q[HOST_EN_BIT];
  wire [1:0] fmt = host_en ? mode_q[FMT_LSB+:2] : cl[SY_FMT+:2];
  wire [1:0] spd = host_en ? mode_q[SPD_LSB+:2] : cl[SY_SPD+:2];
  wire [2:0] dsel = host_en ? mode_q[DIV_LSB+:3] : cl[SY_DIV+:3];
  wire master = spd != SPD_SLAVE;
  wire tdm = fmt == FMT_TDM;
  wire i2s = fmt == FMT_I2S;
  wire lr = fmt == FMT_LJ || i2s;
  wire use_xtal = cl[SY_XSEL];

  //////////////////////////////////////////////////////////////////////////////
  // master clock source and pre-divider
  wire mck = use_xtal ? cl[SY_XTAL] : cl[SY_MCLK];
  logic mck_q;
  logic [3:0] acc_q;
  wire half_tick = mck != mck_q;
  // half-period units let the 1.5 ratio come out of the same accumulator
  wire [3:0] ratio = dsel == DIV_1P5 ? RATIO_1P5 : dsel == DIV_2 ? RATIO_2 :
                     dsel == DIV_3 ? RATIO_3 : dsel == DIV_4 ? RATIO_4 : RATIO_1;
  wire [4:0] acc_sum = {1'b0, acc_q} + 5'h02;
  wire dtick = half_tick && acc_sum >= {1'b0, ratio};
  wire [4:0] acc_nx = dtick ? acc_sum - {1'b0, ratio} : acc_sum;
  wire [3:0] acc_d = half_tick ? acc_nx[3:0] : acc_q;

  //////////////////////////////////////////////////////////////////////////////
  // bit clock and frame clock generation
  logic [1:0] det_q;
  wire [1:0] spd_run = master ? spd : det_q;
  // TDM above single speed would need a sub-cycle half period; clamped to one
  wire [2:0] half_len = !lr ? HALF_ONE : spd_run == SPD_SINGLE ? HALF_LR_SINGLE :
                        spd_run == SPD_DOUBLE ? HALF_LR_DOUBLE : HALF_ONE;
  logic [2:0] hcnt_q;
  logic msclk_q;
  logic [7:0] mcnt_q;
  wire [2:0] hcnt_inc = hcnt_q + 3'h1;
  wire sedge = master && dtick && hcnt_inc >= half_len;
  wire m_fall = sedge && msclk_q;
  wire [5:0] lr_inc = mcnt_q[5:0] + 6'h01;
  wire [7:0] mcnt_nx = lr ? {2'b00, lr_inc} : mcnt_q + 8'h01;
  wire m_fclk = tdm ? mcnt_nx[7:5] == 3'h0 : (i2s ? mcnt_nx[5] : ~mcnt_nx[5]);

  logic sclk_p_q;
  wire sclk_s = cl[SY_SCLK];
  wire fclk_s = cl[SY_FCLK];
  wire s_fall = !master && sclk_p_q && !sclk_s;
  wire fall_ev = m_fall || s_fall;

  //////////////////////////////////////////////////////////////////////////////
  // framing: position in channel or frame, advanced on falling bit clock
  logic fclk_prev_q;
  logic [7:0] pos_q;
  logic half_q;
  logic [SAMPLE_W*CHANNELS-1:0] shadow_q;
  wire fclk_at = master ? m_fclk : fclk_s;
  wire bound = tdm ? fclk_at && !fclk_prev_q : fclk_at != fclk_prev_q;
  wire [7:0] pos_d = bound ? 8'h00 : (pos_q == 8'hFF ? pos_q : pos_q + 8'h01);
  wire left = i2s ? !fclk_at : fclk_at;
  wire half_d = lr ? !left : half_q;
  wire [7:0] pos_m1 = pos_d - 8'h01;
  wire [7:0] lr_idx = i2s ? pos_m1 : pos_d;
  wire lr_ok = lr_idx < WORD_BITS && !(i2s && pos_d == 8'h00);
  wire [2:0] slot = pos_d[7:5];
  wire t_ok = pos_d[4:0] < WORD_BITS[4:0] && slot < TDM_CHANNELS;
  wire ok = tdm ? t_ok : lr_ok;
  wire [4:0] bi = !ok ? 5'h00 : tdm ? pos_d[4:0] : lr_idx[4:0];
  wire [4:0] bsel = WORD_MSB - bi;
  wire [2:0] ch_a = tdm ? (t_ok ? slot : 3'h0) : {2'b00, half_d};
  wire [2:0] ch_b = 3'h2 + {2'b00, half_d};
  wire [2:0] ch_c = 3'h4 + {2'b00, half_d};
  wire start = fall_ev && bound && (tdm || left);
  // the first bit of a frame leaves in the same event that captures the words
  wire [SAMPLE_W*CHANNELS-1:0] cur = start ? samples : shadow_q;
  wire [SAMPLE_W-1:0] word_a = cur[ch_a*SAMPLE_W+:SAMPLE_W];
  wire [SAMPLE_W-1:0] word_b = cur[ch_b*SAMPLE_W+:SAMPLE_W];
  wire [SAMPLE_W-1:0] word_c = cur[ch_c*SAMPLE_W+:SAMPLE_W];
  wire bit_a = ok && fmt != FMT_RSV && word_a[bsel];
  wire bit_b = ok && lr && word_b[bsel];
  wire bit_c = tdm ? !bit_a : ok && lr && word_c[bsel];

  //////////////////////////////////////////////////////////////////////////////
  // slave speed auto-detect
  logic fr_q;
  logic [9:0] rcnt_q;
  wire f_rise = !master && fclk_s && !fr_q;
  wire [9:0] rcnt_inc = rcnt_q == DET_SAT ? rcnt_q : rcnt_q + 10'h001;
  wire [1:0] det_new = rcnt_q >= DET_SINGLE_MIN ? SPD_SINGLE :
                       rcnt_q >= DET_DOUBLE_MIN ? SPD_DOUBLE : SPD_QUAD;

  //////////////////////////////////////////////////////////////////////////////
  // register port
  wire [7:0] status = {2'b00, host_en, fmt, !master, spd_run};
  wire [7:0] rd_val = reg_addr == ADDR_GLOBAL ? global_q : reg_addr == ADDR_MODE ? mode_q :
                      reg_addr == ADDR_STATUS ? status : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_q <= GLOBAL_RST;
      mode_q <= MODE_RST;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == ADDR_GLOBAL) begin
        global_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_MODE) begin
        mode_q <= reg_wdata;
      end
      reg_rdata <= reg_rd ? rd_val : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mck_q <= 1'b0;
      acc_q <= 4'h0;
      hcnt_q <= 3'h0;
      msclk_q <= 1'b0;
      mcnt_q <= 8'h00;
    end else begin
      mck_q <= mck;
      acc_q <= acc_d;
      if (!master) begin
        hcnt_q <= 3'h0;
        msclk_q <= 1'b0;
      end else if (dtick) begin
        hcnt_q <= sedge ? 3'h0 : hcnt_inc;
        msclk_q <= msclk_q ^ sedge;
      end
      if (m_fall) begin
        mcnt_q <= mcnt_nx;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_p_q <= 1'b0;
      fclk_prev_q <= 1'b0;
      pos_q <= 8'h00;
      half_q <= 1'b0;
      shadow_q <= '0;
    end else begin
      sclk_p_q <= sclk_s;
      if (fall_ev) begin
        fclk_prev_q <= fclk_at;
        pos_q <= pos_d;
        half_q <= half_d;
      end
      if (start) begin
        shadow_q <= samples;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out_a <= 1'b0;
      serial_data_out_b <= 1'b0;
      serial_data_out_c <= 1'b0;
      serial_data_out_d <= 1'b0;
      sample_take <= 1'b0;
    end else begin
      sample_take <= start;
      if (fall_ev) begin
        serial_data_out_a <= bit_a;
        serial_data_out_b <= bit_b;
        serial_data_out_c <= bit_c;
        serial_data_out_d <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_q <= 1'b0;
      rcnt_q <= 10'h000;
      det_q <= SPD_SINGLE;
    end else begin
      fr_q <= fclk_s;
      if (f_rise) begin
        det_q <= det_new;
        rcnt_q <= 10'h000;
      end else if (dtick) begin
        rcnt_q <= rcnt_inc;
      end
    end
  end

  // pin drivers; the slave leaves clock pins to the far end, whose clocks
  // must come from the same master clock for the counts above to hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_o <= 1'b0;
      sclk_oe <= 1'b0;
      frame_clock_o <= 1'b0;
      frame_clock_oe <= 1'b0;
      mclk_o <= 1'b0;
      mclk_oe <= 1'b0;
      crystal_output <= 1'b0;
    end else begin
      sclk_o <= msclk_q;
      sclk_oe <= master;
      if (m_fall) begin
        frame_clock_o <= m_fclk;
      end
      frame_clock_oe <= master;
      mclk_o <= use_xtal && cl[SY_XTAL];
      mclk_oe <= use_xtal;
      crystal_output <= use_xtal && !cl[SY_XTAL];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tdm_comp;
    $past(fall_ev) && $past(tdm) |-> serial_data_out_c == !serial_data_out_a;
  endproperty
  a_tdm_comp: assert property (p_tdm_comp) else $error("tdm complement lost");

  property p_master_drive;
    master |=> sclk_oe && frame_clock_oe;
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("master clocks not driven");

  property p_slave_release;
    !master |=> !sclk_oe && !frame_clock_oe;
  endproperty
  a_slave_release: assert property (p_slave_release) else $error("slave drives clocks");

  property p_pad_zero;
    fall_ev && lr && !bound && pos_q >= WORD_BITS |=> !serial_data_out_a && !serial_data_out_b;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("no zero padding");

  property p_host_wins;
    reg_wr && reg_addr == ADDR_MODE && host_en |=> fmt == $past(reg_wdata[1:0]);
  endproperty
  a_host_wins: assert property (p_host_wins) else $error("register did not override");

  property p_tdm_start;
    fall_ev && tdm && fclk_at && !fclk_prev_q |=> pos_q == 8'h00 && sample_take;
  endproperty
  a_tdm_start: assert property (p_tdm_start) else $error("tdm frame did not restart");

  property p_lr_wrap;
    m_fall && lr && mcnt_q == 8'h3F |=> mcnt_q == 8'h00;
  endproperty
  a_lr_wrap: assert property (p_lr_wrap) else $error("master frame not 64 bits");

  property p_detect;
    f_rise && rcnt_q >= DET_SINGLE_MIN |=> det_q == SPD_SINGLE;
  endproperty
  a_detect: assert property (p_detect) else $error("single speed not detected");

  property p_msb_first;
    start && fmt == FMT_LJ |=> serial_data_out_a == $past(samples[SAMPLE_W-1]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not ch1 msb");

  property p_no_crystal;
    !use_xtal |=> !mclk_oe && !crystal_output;
  endproperty
  a_no_crystal: assert property (p_no_crystal) else $error("mclk pin driven");

  c_tdm_frame: cover property (start && tdm);
  c_i2s_frame: cover property (start && i2s);
  c_detect_quad: cover property (f_rise && det_new == SPD_QUAD);
endmodule

//--- verif/asp_far_end.sv
// Purpose: far-end model that supplies the master clock and, when asked, slave bit and frame clocks
// Assumes: master clock half period 40 ns, well below a quarter of the system clock
// Notes: one bit clock lasts four master-clock half periods; frame clock high marks the odd channel
`timescale 1ns/1ps
module asp_far_end (
  output logic mclk,
  input wire logic slave_on,
  input wire logic [7:0] slave_bits,
  output logic sclk_drv,
  output logic fs_drv
);
  //////////////////////////////////////////////////////////////////////////////
  // offset start keeps master clock edges away from system clock edges
  initial begin
    mclk = 1'b0;
    #3;
    forever #40 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // bit and frame clocks move only on master clock edges, so both stay locked to it
  initial begin
    int nb;
    sclk_drv = 1'b0;
    fs_drv = 1'b0;
    forever begin
      @(posedge mclk);
      if (slave_on) begin
        // frame length is latched so a change of slave_bits never splits a frame
        nb = slave_bits;
        for (int ch = 0; ch < 2; ch++) begin
          for (int j = 0; j < nb; j++) begin
            sclk_drv = 1'b0;
            if (j == 0) fs_drv = (ch == 0);
            repeat (2) @(mclk);
            sclk_drv = 1'b1;
            repeat (2) @(mclk);
          end
        end
      end
    end
  end
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the serial audio clocking and output port
// Assumes: far-end model drives master clock, and bit and frame clocks in slave mode
// Notes: after the pin check every setting except the use_crystal pin goes through the host port
`timescale 1ns/1ps
module tb
  import asp_pkg::*;
();
  `define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
  logic clk, rst_n, use_crystal, fmt_hi, fmt_lo, spd_hi, spd_lo, reg_wr, reg_rd, slave_on;
  logic [2:0] div_sel;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, slave_bits, reg_rdata;
  logic crystal_output, mclk_o, mclk_oe, sclk_o, sclk_oe, fs_o, fs_oe, sample_take;
  logic sd_a, sd_b, sd_c, sd_d;
  logic [SAMPLE_W*CHANNELS-1:0] samples;
  logic [255:0] va, vb, vc, vd, e;
  wire xtal, mclk_w, sclk_w, fs_w, prt_mclk, sclk_drv, fs_drv;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_fs = 0;
  int n_mo = 0;
  int n_st = 0;
  int f0;
  assign xtal = use_crystal ? prt_mclk : 1'b0;
  assign mclk_w = mclk_oe ? mclk_o : prt_mclk;
  assign sclk_w = sclk_oe ? sclk_o : sclk_drv;
  assign fs_w = fs_oe ? fs_o : fs_drv;
  asp_port dut_u (
    .clk(clk), .rst_n(rst_n), .use_crystal(use_crystal), .crystal_input(xtal), .crystal_output(crystal_output),
    .mclk_i(mclk_w), .mclk_o(mclk_o), .mclk_oe(mclk_oe), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .frame_clock_i(fs_w), .frame_clock_o(fs_o), .frame_clock_oe(fs_oe), .serial_data_out_a(sd_a),
    .serial_data_out_b(sd_b), .serial_data_out_c(sd_c), .serial_data_out_d(sd_d), .format_select_hi(fmt_hi),
    .format_select_lo(fmt_lo), .speed_select_hi(spd_hi), .speed_select_lo(spd_lo), .clock_div_select(div_sel),
    .samples(samples), .sample_take(sample_take), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  asp_far_end prt_u (.mclk(prt_mclk), .slave_on(slave_on), .slave_bits(slave_bits), .sclk_drv(sclk_drv), .fs_drv(fs_drv));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge fs_w) n_fs++;
  always @(posedge mclk_o) n_mo++;
  always @(posedge clk) if (sample_take) n_st++;
  // the whole run needs about 40k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] word(int k);
    return 24'(24'h800001 + 24'h010100 * k);
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] ex, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", ex, reg_rdata & m)
  endtask
  // a late start models the one-bit delay of the I2S word
  task automatic push(input logic [23:0] w, input int bits, input int late);
    for (int j = 0; j < bits; j++) begin
      e = {e[254:0], (j >= late && j - late < SAMPLE_W) ? w[SAMPLE_W-1-j+late] : 1'b0};
    end
  endtask
  task automatic grab(input int n, input logic i2s);
    int s0;
    if (i2s) @(negedge fs_w);
    else @(posedge fs_w);
    #1;
    f0 = n_fs;
    s0 = n_st;
    {va, vb, vc, vd} = '0;
    repeat (n) begin
      @(posedge sclk_w);
      {va, vb, vc, vd} = {va[254:0], sd_a, vb[254:0], sd_b, vc[254:0], sd_c, vd[254:0], sd_d};
    end
    `CHK("sample_take", 1, n_st - s0)
  endtask
  task automatic chk_lr(input int bits, input int late);
    for (int p = 0; p < 3; p++) begin
      e = '0;
      push(word(2 * p), bits, late);
      push(word(2 * p + 1), bits, late);
      `CHK("lr_data", e, p == 0 ? va : p == 1 ? vb : vc)
    end
    `CHK("lr_pin_d", 256'h0, vd)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(ADDR_GLOBAL, GLOBAL_RST, 8'hFF);
    rd_chk(ADDR_MODE, MODE_RST, 8'hFF);
    rd_chk(4'hC, 8'h00, 8'hFF);
    wr(ADDR_STATUS, 8'hFF);
    rd_chk(ADDR_STATUS, 8'h00, 8'h3F);
    wr(ADDR_MODE, 8'h36);
    rd_chk(ADDR_MODE, 8'h36, 8'h7F);
    `CHK("ext_mclk", 3'b000, {mclk_oe, mclk_o, crystal_output})
    $display("test registers done");
  endtask
  task automatic t_codes();
    {fmt_hi, fmt_lo, spd_hi, spd_lo} <= 4'hF;
    repeat (6) @(posedge clk);
    rd_chk(ADDR_STATUS, 8'h1C, 8'h3C);
    `CHK("oe_slave", 2'b00, {sclk_oe, fs_oe})
    wr(ADDR_GLOBAL, 8'h80);
    rd_chk(ADDR_GLOBAL, 8'h80, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MODE, {4'h0, 2'(i), 2'(i)});
      repeat (4) @(posedge clk);
      rd_chk(ADDR_STATUS, {3'b001, 2'(i), i == 3, i == 3 ? 2'b00 : 2'(i)}, i == 3 ? 8'h3C : 8'h3F);
      `CHK("oe_mode", {2{i != 3}}, {sclk_oe, fs_oe})
    end
    {fmt_hi, fmt_lo, spd_hi, spd_lo} <= 4'h0;
    $display("test codes done");
  endtask
  task automatic t_reserved();
    int bad;
    bad = 0;
    wr(ADDR_MODE, {4'h0, SPD_SINGLE, FMT_RSV});
    // long enough for at least two bit clock falls to flush older pin levels
    repeat (20) @(posedge clk);
    repeat (300) begin
      @(posedge clk);
      if (sd_a !== 1'b0) bad++;
    end
    `CHK("rsv_pin_a", 0, bad)
    $display("test reserved format done");
  endtask
  task automatic t_master(input logic [1:0] f);
    wr(ADDR_MODE, {4'h0, SPD_SINGLE, f});
    repeat (2) @(posedge fs_w);
    `CHK("master_oe", 2'b11, {sclk_oe, fs_oe})
    grab(f == FMT_TDM ? 256 : 64, f == FMT_I2S);
    if (f != FMT_I2S) begin
      `CHK("frame_len", f0, n_fs)
      @(posedge sclk_w);
      `CHK("frame_len", f0 + 1, n_fs)
    end
    if (f == FMT_TDM) begin
      e = '0;
      for (int k = 0; k < 8; k++) push(k < CHANNELS ? word(k) : 24'h0, 32, 0);
      `CHK("tdm_a", e, va)
      `CHK("tdm_c", ~e, vc)
      `CHK("tdm_bd", 512'h0, {vb, vd})
    end else begin
      chk_lr(32, f == FMT_I2S);
    end
    $display("test master format %0d done", f);
  endtask
  task automatic t_div();
    logic [2:0] code [5];
    logic [3:0] ratio [5];
    int t0;
    code = '{3'h0, DIV_1P5, DIV_2, DIV_3, DIV_4};
    ratio = '{RATIO_1, RATIO_1P5, RATIO_2, RATIO_3, RATIO_4};
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_MODE, {1'b0, code[k], SPD_SINGLE, FMT_LJ});
      repeat (4) @(posedge sclk_w);
      #1;
      t0 = cyc;
      @(posedge sclk_w);
      #1;
      `CHK("sclk_period", 16 * ratio[k], cyc - t0)
    end
    // double and quad speed halve the bit clock period each time at ratio 1
    for (int s = 1; s < 3; s++) begin
      wr(ADDR_MODE, {4'h0, 2'(s), FMT_LJ});
      repeat (4) @(posedge sclk_w);
      #1;
      t0 = cyc;
      @(posedge sclk_w);
      #1;
      `CHK("sclk_speed", 32 >> s, cyc - t0)
    end
    $display("test dividers done");
  endtask
  // 64 bits per channel gives single speed with padding, 20 gives quad with a cut word
  task automatic t_slave(input int bits);
    logic [1:0] sp;
    sp = (8 * bits >= DET_SINGLE_MIN) ? SPD_SINGLE : (8 * bits >= DET_DOUBLE_MIN) ? SPD_DOUBLE : SPD_QUAD;
    slave_bits <= 8'(bits);
    repeat (3) @(posedge fs_w);
    grab(2 * bits, 1'b0);
    chk_lr(bits, 0);
    rd_chk(ADDR_STATUS, {3'b001, FMT_LJ, 1'b1, sp}, 8'h3F);
    $display("test slave %0d bits done", bits);
  endtask
  task automatic t_xtal();
    int n0;
    use_crystal <= 1'b1;
    repeat (50) @(posedge clk);
    `CHK("mclk_oe", 1'b1, mclk_oe)
    n0 = n_mo;
    repeat (400) @(posedge clk);
    `CHK("mclk_copy", 1'b1, n_mo - n0 >= 49 && n_mo - n0 <= 51)
    use_crystal <= 1'b0;
    $display("test crystal done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {use_crystal, fmt_hi, fmt_lo, spd_hi, spd_lo, reg_wr, reg_rd, slave_on} = '0;
    div_sel = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    slave_bits = 8'h20;
    for (int k = 0; k < CHANNELS; k++) samples[SAMPLE_W*k +: SAMPLE_W] = word(k);
    repeat (8) @(posedge clk);
    @(negedge mclk_w);
    rst_n <= 1'b1;
    t_regs();
    t_codes();
    t_reserved();
    t_master(FMT_LJ);
    t_master(FMT_I2S);
    t_master(FMT_TDM);
    t_div();
    wr(ADDR_MODE, {4'h0, SPD_SLAVE, FMT_LJ});
    slave_on <= 1'b1;
    t_slave(64);
    t_slave(32);
    t_slave(20);
    slave_on <= 1'b0;
    t_xtal();
    conclude();
  end
endmodule
